// ### pcsr_led.sv
// LED pulse stretcher with bypass
`timescale 1ns/1ps
module pcsr_led #(
  parameter int N   = 3,
  parameter int LEN = pcsr_pkg::LED_STRETCH_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         bypass,
  input  wire logic [N-1:0] raw,
  output logic      [N-1:0] led
);

  typedef struct packed {
    logic [N-1:0][15:0] cnt;
    logic [N-1:0]       led;
  } pcsr_led_st_t;

  pcsr_led_st_t st;
  pcsr_led_st_t next_st;

  assign led = st.led;

  // Each event holds its LED for LEN cycles unless bypassed
  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      if (raw[i]) begin
        next_st.cnt[i] = 16'(LEN);
      end else if (st.cnt[i] != 16'h0000) begin
        next_st.cnt[i] = st.cnt[i] - 16'h0001;
      end
      next_st.led[i] = bypass ? raw[i] : (raw[i] | (st.cnt[i] != 16'h0000));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : pcsr_led

// ### pcsr_lfsr.sv
// Self-test pattern generator and checker with selectable sequence length
`timescale 1ns/1ps
module pcsr_lfsr (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic long_seq,
  input  wire logic loop_bit,
  output logic      pattern,
  output logic      error
);

  typedef struct packed {
    logic [14:0] gen;
    logic [14:0] chk;
    logic        err;
    logic        primed;
  } pcsr_lfsr_st_t;

  pcsr_lfsr_st_t st;
  pcsr_lfsr_st_t next_st;

  // Feedback tap for either length
  function automatic logic pcsr_fb(input logic [14:0] s, input logic l);
    pcsr_fb = l ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
  endfunction : pcsr_fb

  assign pattern = st.gen[0];
  assign error   = st.err;

  // Generator shifts, checker follows looped bit and flags mismatches
  // Checker lags the generator by one bit, so the first run cycle is only used to prime it
  always_comb begin
    next_st = st;
    if (run) begin
      next_st.gen    = {st.gen[13:0], pcsr_fb(st.gen, long_seq)};
      next_st.chk    = {st.chk[13:0], loop_bit};
      next_st.primed = 1'b1;
      if (st.primed && (loop_bit != pcsr_fb(st.chk, long_seq))) begin
        next_st.err = 1'b1;
      end
    end else begin
      next_st.gen    = 15'h7FFF;
      next_st.chk    = 15'h7FFF;
      next_st.err    = 1'b0;
      next_st.primed = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '{gen: 15'h7FFF, chk: 15'h7FFF, err: 1'b0, primed: 1'b0};
    end else begin
      st <= next_st;
    end
  end

endmodule : pcsr_lfsr

// ### pcsr_pkg.sv
// Package: offsets, field positions, reset values and timing for the PHY control register bank
package pcsr_pkg;

  // Register byte offsets from the I/O base
  localparam logic [7:0] OFF_PAGE_SELECT = 8'h00_CC;
  localparam logic [7:0] OFF_PHY_CONTROL = 8'h00_E4;
  localparam logic [7:0] OFF_TENBASE     = 8'h00_E8;
  localparam logic [7:0] OFF_DSP_CONFIG  = 8'h00_F4;
  localparam logic [7:0] OFF_SIG_DETECT  = 8'h00_F8;
  localparam logic [7:0] OFF_TEST_DATA   = 8'h00_FC;

  // Page that exposes the paged PMD control at the shared offset
  localparam logic [15:0] PAGE_PMD = 16'h0001;

  // Reset values
  localparam logic [15:0] RST_PHY_CONTROL = 16'h003F;
  localparam logic [15:0] RST_TENBASE     = 16'h0004;
  localparam logic [15:0] RST_ZERO        = 16'h0000;

  // Writable masks; other control bits keep their value but the result clears, other 10BASE-T bits clear on write except polarity, which follows its latch
  localparam logic [15:0] MASK_PHY_CONTROL = 16'h0B1F;
  localparam logic [15:0] MASK_TENBASE     = 16'h01EF;

  // Field positions, control register
  localparam int B_LONG_SEQ    = 11;
  localparam int B_ST_RESULT   = 10;
  localparam int B_ST_RUN      = 9;
  localparam int B_LED_BYPASS  = 8;
  localparam int B_PAUSE_CMP   = 7;
  localparam int B_ADDR_HI     = 4;

  // Field positions, 10BASE-T register
  localparam int B_LOOPBACK    = 8;
  localparam int B_LP_DISABLE  = 7;
  localparam int B_FORCE_LINK  = 6;
  localparam int B_FORCE_POL   = 5;
  localparam int B_POLARITY    = 4;
  localparam int B_AUTO_POLARITY_DISABLE = 3;
  localparam int B_HEARTBEAT   = 1;
  localparam int B_JABBER      = 0;

  // Loopback bit inside the basic mode control register
  localparam int B_BMC_LOOPBACK = 14;

  // Recommended minimum self-test run time
  localparam int  SELF_TEST_MIN_US  = 1000;
  localparam int  CLK_MHZ           = 125;
  localparam int  SELF_TEST_MIN_CYC = SELF_TEST_MIN_US * CLK_MHZ;

  // LED stretch length
  localparam int LED_STRETCH_CYC = 4000;

  // Register bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } pcsr_req_t;

  // Line-side status inputs
  typedef struct packed {
    logic       pause_local;
    logic       pause_partner;
    logic       pol_inverted;
    logic       full_duplex;
    logic       speed_100;
    logic       link_raw;
    logic [2:0] led_raw;
  } pcsr_line_t;

endpackage : pcsr_pkg

// ### pcsr_regs.sv
// PHY control and 10BASE-T status/control register bank with derived controls
// Behaviour
// - Sequence select picks 15 or 9 stage
// - Run bit starts self test until cleared
// - Result latches pass, clears on run write
// - Bypass bit drives LEDs unstretched
// - Pause status is local AND partner
// - Management address read-write, resets all ones
// - Loopback bit ORed with basic mode loopback
// - Link pulse disable stops normal link pulses
// - Force link ORed with MAC force input
// - Force bit inverts receive polarity
// - Polarity latches high, cleared by either read
// - Auto polarity disable stops sensing
// - Heartbeat disable only in half-duplex 10
// - Jabber disable turns jabber off
// - Registers decoded at base plus offset
// - Hard reset values 003F and 0004
`timescale 1ns/1ps
module pcsr_regs #(
  parameter int SELF_TEST_CYC = pcsr_pkg::SELF_TEST_MIN_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [7:0]         io_base,
  input  wire pcsr_pkg::pcsr_req_t req,
  output logic      [15:0]        rdata,
  output logic                    rvalid,
  input  wire logic [15:0]        basic_mode_control,
  input  wire logic               mac_slow_link_force_in,
  input  wire pcsr_pkg::pcsr_line_t line,
  input  wire logic               phy_status_rd,
  output logic                    phy_status_polarity,
  output logic                    slow_loopback_en,
  output logic                    normal_link_pulse_en,
  output logic                    slow_link_good,
  output logic                    rx_polarity_invert,
  output logic                    auto_polarity_en,
  output logic                    heartbeat_en,
  output logic                    jabber_en,
  output logic      [2:0]         led,
  output logic                    self_test_pattern,
  output logic                    self_test_min_done,
  output logic      [4:0]         mgmt_port_address
);

  typedef struct packed {
    logic [15:0] page_select;
    logic [15:0] phy_control;
    logic [15:0] pmd_control_paged;
    logic [15:0] tenbase;
    logic [15:0] dsp_config;
    logic [15:0] signal_detect_config;
    logic [15:0] test_data;
    logic [2:0]  pol_sync;
    logic        pol_seen;
    logic [2:0]  pause_sync;
    logic [2:0]  lp_sync;
    logic [2:0]  link_sync;
    logic [23:0] run_cnt;
    logic        min_done;
    logic [15:0] rdata;
    logic        rvalid;
    logic        slow_loopback_en;
    logic        nlp_en;
    logic        link_good;
    logic        pol_inv;
    logic        autopol_en;
    logic        heartbeat_en;
    logic        jabber_en;
  } pcsr_regs_st_t;

  pcsr_regs_st_t st;
  pcsr_regs_st_t next_st;

  logic       st_error;
  logic [2:0] led_q;
  logic       rd_hit_tb;
  logic       self_test_pattern_w;

  // Base plus offset decode
  function automatic logic pcsr_hit(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] off);
    pcsr_hit = (a == 8'(base + off));
  endfunction : pcsr_hit

  // Polarity filter: second and third stages agree
  function automatic logic pcsr_agree(input logic [2:0] s);
    pcsr_agree = s[1] & s[2];
  endfunction : pcsr_agree

  pcsr_lfsr u_lfsr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .run      (st.phy_control[pcsr_pkg::B_ST_RUN]),
    .long_seq (st.phy_control[pcsr_pkg::B_LONG_SEQ]),
    .loop_bit (self_test_pattern_w),
    .pattern  (self_test_pattern_w),
    .error    (st_error)
  );

  pcsr_led #(
    .N   (3),
    .LEN (pcsr_pkg::LED_STRETCH_CYC)
  ) u_led (
    .core_clk (core_clk),
    .rstn     (rstn),
    .bypass   (st.phy_control[pcsr_pkg::B_LED_BYPASS]),
    .raw      (line.led_raw),
    .led      (led_q)
  );

  assign rd_hit_tb = req.rd && pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_TENBASE);

  // Register next state, status capture and derived controls
  always_comb begin
    next_st            = st;
    next_st.rvalid     = 1'b0;
    next_st.pol_sync   = {st.pol_sync[1:0], line.pol_inverted};
    next_st.pause_sync = {st.pause_sync[1:0], line.pause_local & line.pause_partner};
    next_st.lp_sync    = {st.lp_sync[1:0], line.full_duplex};
    next_st.link_sync  = {st.link_sync[1:0], line.link_raw};

    // Pause compare status follows both capabilities
    next_st.phy_control[pcsr_pkg::B_PAUSE_CMP] = pcsr_agree(st.pause_sync);

    // Self-test run timer and latched result
    if (st.phy_control[pcsr_pkg::B_ST_RUN]) begin
      if (st.run_cnt != 24'(SELF_TEST_CYC)) begin
        next_st.run_cnt = st.run_cnt + 24'h00_0001;
      end
      next_st.min_done = (st.run_cnt >= 24'(SELF_TEST_CYC - 1));
      next_st.phy_control[pcsr_pkg::B_ST_RESULT] = ~st_error;
    end

    // Reads return data, polarity clears on either read
    if (req.rd) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 16'h0000;
      if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_PAGE_SELECT)) begin
        next_st.rdata = st.page_select;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_PHY_CONTROL)) begin
        next_st.rdata = (st.page_select == pcsr_pkg::PAGE_PMD) ? st.pmd_control_paged
                                                               : st.phy_control;
      end else if (rd_hit_tb) begin
        next_st.rdata = st.tenbase;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_DSP_CONFIG)) begin
        next_st.rdata = st.dsp_config;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_SIG_DETECT)) begin
        next_st.rdata = st.signal_detect_config;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_TEST_DATA)) begin
        next_st.rdata = st.test_data;
      end
    end
    if (rd_hit_tb || phy_status_rd) begin
      next_st.pol_seen = 1'b0;
    end

    // Writes; paged control shares the control offset
    if (req.wr) begin
      if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_PAGE_SELECT)) begin
        next_st.page_select = req.wdata;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_PHY_CONTROL)) begin
        if (st.page_select == pcsr_pkg::PAGE_PMD) begin
          next_st.pmd_control_paged = req.wdata;
        end else begin
          next_st.phy_control = (req.wdata & pcsr_pkg::MASK_PHY_CONTROL)
                              | (next_st.phy_control & ~pcsr_pkg::MASK_PHY_CONTROL);
          next_st.phy_control[pcsr_pkg::B_ST_RESULT] = 1'b0;
          next_st.run_cnt  = 24'h00_0000;
          next_st.min_done = 1'b0;
        end
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_TENBASE)) begin
        next_st.tenbase = (req.wdata & pcsr_pkg::MASK_TENBASE);
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_DSP_CONFIG)) begin
        next_st.dsp_config = req.wdata;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_SIG_DETECT)) begin
        next_st.signal_detect_config = req.wdata;
      end else if (pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_TEST_DATA)) begin
        next_st.test_data = req.wdata;
      end
    end

    // Inverted polarity detect sets over a same-cycle clear
    if (pcsr_agree(st.pol_sync) && st.autopol_en) begin
      next_st.pol_seen = 1'b1;
    end
    next_st.tenbase[pcsr_pkg::B_POLARITY] = next_st.pol_seen;

    // Derived line controls
    next_st.slow_loopback_en = st.tenbase[pcsr_pkg::B_LOOPBACK]
                             | basic_mode_control[pcsr_pkg::B_BMC_LOOPBACK];
    next_st.nlp_en = ~(st.tenbase[pcsr_pkg::B_LP_DISABLE] | mac_slow_link_force_in);
    next_st.link_good = st.tenbase[pcsr_pkg::B_FORCE_LINK] | mac_slow_link_force_in
                      | pcsr_agree(st.link_sync);
    next_st.pol_inv    = st.tenbase[pcsr_pkg::B_FORCE_POL];
    next_st.autopol_en = ~st.tenbase[pcsr_pkg::B_AUTO_POLARITY_DISABLE];
    next_st.heartbeat_en = ~line.speed_100 & ~pcsr_agree(st.lp_sync)
                         & ~st.tenbase[pcsr_pkg::B_HEARTBEAT];
    next_st.jabber_en = ~st.tenbase[pcsr_pkg::B_JABBER];
  end

  // Hard reset values
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st             <= '0;
      st.phy_control <= pcsr_pkg::RST_PHY_CONTROL;
      st.tenbase     <= pcsr_pkg::RST_TENBASE;
      st.nlp_en      <= 1'b1;
      st.autopol_en  <= 1'b1;
      st.jabber_en   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata                = st.rdata;
  assign rvalid               = st.rvalid;
  assign phy_status_polarity  = st.pol_seen;
  assign slow_loopback_en     = st.slow_loopback_en;
  assign normal_link_pulse_en = st.nlp_en;
  assign slow_link_good       = st.link_good;
  assign rx_polarity_invert   = st.pol_inv;
  assign auto_polarity_en     = st.autopol_en;
  assign heartbeat_en         = st.heartbeat_en;
  assign jabber_en            = st.jabber_en;
  assign led                  = led_q;
  assign self_test_pattern    = self_test_pattern_w;
  assign self_test_min_done   = st.min_done;
  assign mgmt_port_address    = st.phy_control[pcsr_pkg::B_ADDR_HI:0];

  // Checks
  property p_reset_ctrl;
    @(posedge core_clk) !rstn |=> (st.phy_control == pcsr_pkg::RST_PHY_CONTROL);
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control reset value wrong");

  property p_reset_tb;
    @(posedge core_clk) !rstn |=> (st.tenbase == pcsr_pkg::RST_TENBASE);
  endproperty
  a_reset_tb: assert property (p_reset_tb) else $error("10BASE-T reset value wrong");

  property p_loopback;
    @(posedge core_clk) disable iff (!rstn)
      (st.tenbase[pcsr_pkg::B_LOOPBACK] || basic_mode_control[pcsr_pkg::B_BMC_LOOPBACK])
      |=> slow_loopback_en;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback OR missing");

  property p_force_link;
    @(posedge core_clk) disable iff (!rstn)
      (st.tenbase[pcsr_pkg::B_FORCE_LINK] || mac_slow_link_force_in) |=> slow_link_good;
  endproperty
  a_force_link: assert property (p_force_link) else $error("forced link not good");

  property p_nlp;
    @(posedge core_clk) disable iff (!rstn)
      st.tenbase[pcsr_pkg::B_LP_DISABLE] |=> !normal_link_pulse_en;
  endproperty
  a_nlp: assert property (p_nlp) else $error("link pulses not stopped");

  sequence s_run_write;
    req.wr && pcsr_hit(req.addr, io_base, pcsr_pkg::OFF_PHY_CONTROL)
      && (st.page_select != pcsr_pkg::PAGE_PMD);
  endsequence
  property p_result_clear;
    @(posedge core_clk) disable iff (!rstn)
      s_run_write |=> !st.phy_control[pcsr_pkg::B_ST_RESULT];
  endproperty
  a_result_clear: assert property (p_result_clear) else $error("result not cleared");

  property p_heartbeat;
    @(posedge core_clk) disable iff (!rstn) line.speed_100 |=> !heartbeat_en;
  endproperty
  a_heartbeat: assert property (p_heartbeat) else $error("heartbeat active at 100");

  property p_reserved;
    @(posedge core_clk) disable iff (!rstn)
      ((st.phy_control & 16'hF040) == 16'h0000) && ((st.tenbase & 16'hFE00) == 16'h0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_pol_clear;
    @(posedge core_clk) disable iff (!rstn)
      (phy_status_rd && !pcsr_agree(st.pol_sync)) |=> !phy_status_polarity;
  endproperty
  a_pol_clear: assert property (p_pol_clear) else $error("polarity not cleared");

endmodule : pcsr_regs

// ### pcsr_tb.sv
// Self-checking testbench for the PHY control register bank
`timescale 1ns/1ps
module tb;
  localparam int ST_CYC = 20;
  localparam int LIMIT  = 40000;
  logic                core_clk;
  logic                rstn;
  logic [7:0]          io_base;
  pcsr_pkg::pcsr_req_t req;
  logic [15:0]         rdata;
  logic                rvalid;
  logic [15:0]         bmc;
  logic                mac_force;
  pcsr_pkg::pcsr_line_t line;
  logic                phy_status_rd;
  logic                pol_copy, lb_en, nlp_en, link_good, pol_inv, apol_en, hb_en, jab_en;
  logic [2:0]          led;
  logic                pattern, min_done;
  logic [4:0]          mgmt_addr;
  int                  errors, checks_done, cycles, seed, n;
  logic [15:0]         page_m, phy_m, pmd_m, tb_m, dsp_m, sd_m, tst_m, w;
  logic                st_m, pause_m, pol_m;
  logic [2:0]          r;
  logic                bits [0:1199];

  pcsr_regs #(.SELF_TEST_CYC(ST_CYC)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .io_base(io_base), .req(req), .rdata(rdata),
    .rvalid(rvalid), .basic_mode_control(bmc), .mac_slow_link_force_in(mac_force),
    .line(line), .phy_status_rd(phy_status_rd), .phy_status_polarity(pol_copy),
    .slow_loopback_en(lb_en), .normal_link_pulse_en(nlp_en), .slow_link_good(link_good),
    .rx_polarity_invert(pol_inv), .auto_polarity_en(apol_en), .heartbeat_en(hb_en),
    .jabber_en(jab_en), .led(led), .self_test_pattern(pattern),
    .self_test_min_done(min_done), .mgmt_port_address(mgmt_addr)
  );

  // Free-running core clock, 8 ns period
  always #4 core_clk = ~core_clk;

  // Hang guard: the whole run needs well under the ceiling
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Model of what a read at an offset must return
  function automatic logic [15:0] exp_rd(input logic [7:0] off);
    case (off)
      pcsr_pkg::OFF_PAGE_SELECT: return page_m;
      pcsr_pkg::OFF_PHY_CONTROL: return (page_m == pcsr_pkg::PAGE_PMD) ? pmd_m :
                                 (phy_m | {5'h00, st_m, 2'b00, pause_m, 7'h00});
      pcsr_pkg::OFF_TENBASE:     return tb_m | {11'h000, pol_m, 4'h0};
      pcsr_pkg::OFF_DSP_CONFIG:  return dsp_m;
      pcsr_pkg::OFF_SIG_DETECT:  return sd_m;
      pcsr_pkg::OFF_TEST_DATA:   return tst_m;
      default:                   return 16'h0000;
    endcase
  endfunction : exp_rd

  // One write strobe, then the model follows
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: 8'(io_base + off), wdata: d};
    @(posedge core_clk);
    req.wr <= 1'b0;
    case (off)
      pcsr_pkg::OFF_PAGE_SELECT: page_m = d;
      pcsr_pkg::OFF_PHY_CONTROL: begin
        if (page_m == pcsr_pkg::PAGE_PMD) begin
          pmd_m = d;
        end else begin
          // Non-writable bits keep their hard reset value
          phy_m = (d & pcsr_pkg::MASK_PHY_CONTROL)
                | (pcsr_pkg::RST_PHY_CONTROL & ~pcsr_pkg::MASK_PHY_CONTROL);
          st_m  = 1'b0;
        end
      end
      pcsr_pkg::OFF_TENBASE:     tb_m  = d & pcsr_pkg::MASK_TENBASE;
      pcsr_pkg::OFF_DSP_CONFIG:  dsp_m = d;
      pcsr_pkg::OFF_SIG_DETECT:  sd_m  = d;
      pcsr_pkg::OFF_TEST_DATA:   tst_m = d;
      default: ;
    endcase
  endtask : wr

  // One read strobe; data is checked in the cycle rvalid stands
  task automatic rd(input logic [7:0] off);
    @(posedge core_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: 8'(io_base + off), wdata: 16'h0000};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", exp_rd(off), rdata);
    if (off == pcsr_pkg::OFF_TENBASE) begin
      pol_m = 1'b0;
    end
  endtask : rd

  initial begin
    core_clk = 1'b0; rstn = 1'b0; io_base = 8'h0020; req = '0; bmc = 16'h0000;
    mac_force = 1'b0; line = '0; phy_status_rd = 1'b0;
    errors = 0; checks_done = 0; cycles = 0; seed = 32'h02f1;
    page_m = 16'h0000; phy_m = pcsr_pkg::RST_PHY_CONTROL; tb_m = pcsr_pkg::RST_TENBASE;
    pmd_m = 16'h0000; dsp_m = 16'h0000; sd_m = 16'h0000; tst_m = 16'h0000;
    st_m = 1'b0; pause_m = 1'b0; pol_m = 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    // Reset values, address wrap past the base and an unmapped place
    rd(pcsr_pkg::OFF_PHY_CONTROL);
    rd(pcsr_pkg::OFF_TENBASE);
    chk("mgmt_addr", 16'h001F, {11'h000, mgmt_addr});
    wr(8'h0040, 16'hFFFF);
    rd(8'h0040);
    wr(pcsr_pkg::OFF_PHY_CONTROL, 16'hFCF5);
    rd(pcsr_pkg::OFF_PHY_CONTROL);
    chk("mgmt_addr", 16'h0015, {11'h000, mgmt_addr});
    // Pause status needs both sides capable
    for (int k = 0; k < 4; k++) begin
      line.pause_local <= k[0];
      line.pause_partner <= k[1];
      repeat (6) @(posedge core_clk);
      pause_m = k[0] & k[1];
      rd(pcsr_pkg::OFF_PHY_CONTROL);
    end
    // Self test with both lengths; the short sequence repeats every 511 bits
    for (int ls = 0; ls < 2; ls++) begin
      wr(pcsr_pkg::OFF_PHY_CONTROL, ls[0] ? 16'h0A1F : 16'h021F);
      st_m = 1'b1;
      rd(pcsr_pkg::OFF_PHY_CONTROL);
      for (int i = 0; i < 1200; i++) begin
        @(posedge core_clk);
        #1 bits[i] = pattern;
      end
      n = 0;
      for (int i = 0; i < 500; i++) n += (bits[i + 100] !== bits[i + 611]);
      chk("seq_repeat", ls[0] ? 16'h0001 : 16'h0000, {15'h0000, n > 0});
      chk("min_done", 16'h0001, {15'h0000, min_done});
      rd(pcsr_pkg::OFF_PHY_CONTROL);
      wr(pcsr_pkg::OFF_PHY_CONTROL, 16'h001F);
      rd(pcsr_pkg::OFF_PHY_CONTROL);
    end
    // LEDs: stretched by default, direct with bypass set
    line.led_raw <= 3'b111;
    repeat (2) @(posedge core_clk);
    line.led_raw <= 3'b000;
    repeat (10) @(posedge core_clk);
    #1 chk("led_stretch", 16'h0007, {13'h0000, led});
    wr(pcsr_pkg::OFF_PHY_CONTROL, 16'h011F);
    for (int i = 0; i < 6; i++) begin
      r = 3'($random(seed));
      line.led_raw <= r;
      repeat (3) @(posedge core_clk);
      #1 chk("led_bypass", {13'h0000, r}, {13'h0000, led});
    end
    // Random 10BASE-T controls against the inputs they combine with
    for (int i = 0; i < 24; i++) begin
      w = 16'($random(seed));
      w = w | 16'h0004;
      bmc <= 16'($random(seed));
      mac_force <= 1'($random(seed));
      line.link_raw <= 1'($random(seed));
      line.speed_100 <= 1'($random(seed));
      line.full_duplex <= 1'($random(seed));
      wr(pcsr_pkg::OFF_TENBASE, w);
      repeat (6) @(posedge core_clk);
      #1;
      chk("loopback", {15'h0000, w[8] | bmc[14]}, {15'h0000, lb_en});
      chk("nlp_en", {15'h0000, ~(w[7] | mac_force)}, {15'h0000, nlp_en});
      chk("link_good", {15'h0000, w[6] | mac_force | line.link_raw},
          {15'h0000, link_good});
      chk("pol_inv", {15'h0000, w[5]}, {15'h0000, pol_inv});
      chk("apol_en", {15'h0000, ~w[3]}, {15'h0000, apol_en});
      chk("heartbeat", {15'h0000, ~w[1] & ~line.speed_100 & ~line.full_duplex},
          {15'h0000, hb_en});
      chk("jabber", {15'h0000, ~w[0]}, {15'h0000, jab_en});
      rd(pcsr_pkg::OFF_TENBASE);
    end
    // Polarity latch, cleared by either read; no sensing when disabled
    for (int k = 0; k < 3; k++) begin
      wr(pcsr_pkg::OFF_TENBASE, (k == 2) ? 16'h000C : 16'h0004);
      line.pol_inverted <= 1'b1;
      repeat (4) @(posedge core_clk);
      line.pol_inverted <= 1'b0;
      repeat (6) @(posedge core_clk);
      pol_m = (k != 2);
      #1 chk("pol_copy", {15'h0000, pol_m}, {15'h0000, pol_copy});
      if (k == 1) begin
        phy_status_rd <= 1'b1;
        @(posedge core_clk);
        phy_status_rd <= 1'b0;
        repeat (2) @(posedge core_clk);
        pol_m = 1'b0;
      end
      rd(pcsr_pkg::OFF_TENBASE);
      rd(pcsr_pkg::OFF_TENBASE);
      #1 chk("pol_copy", 16'h0000, {15'h0000, pol_copy});
    end
    // Recommended ordered sequence through the page select, then page back
    wr(pcsr_pkg::OFF_PAGE_SELECT, pcsr_pkg::PAGE_PMD);
    wr(pcsr_pkg::OFF_PHY_CONTROL, 16'h189C);
    wr(pcsr_pkg::OFF_TEST_DATA, 16'h0000);
    wr(pcsr_pkg::OFF_DSP_CONFIG, 16'h5040);
    wr(pcsr_pkg::OFF_SIG_DETECT, 16'h008C);
    rd(pcsr_pkg::OFF_PAGE_SELECT);
    rd(pcsr_pkg::OFF_PHY_CONTROL);
    rd(pcsr_pkg::OFF_TEST_DATA);
    rd(pcsr_pkg::OFF_DSP_CONFIG);
    rd(pcsr_pkg::OFF_SIG_DETECT);
    wr(pcsr_pkg::OFF_PAGE_SELECT, 16'h0000);
    rd(pcsr_pkg::OFF_PHY_CONTROL);
    // Moving the base moves the 10BASE-T register with it
    io_base = 8'h0000;
    rd(pcsr_pkg::OFF_TENBASE);
    rd(8'h0020);
    report_and_stop();
  end
endmodule : tb
